/* ivfr_top.v */
// input overvoltage response and undervoltage warning logic
`timescale 1ns/100ps
`include "ivfr_consts.vh"
module ivfr_top #(
  parameter RISE_CYCLES = (`IVFR_RISE_TIME_US * 1000000) / `IVFR_CLK_PERIOD_PS,
  parameter TWIDTH      = 24
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // command port
  input  wire        cmdValid,
  input  wire        cmdWrite,
  input  wire [7:0]  cmdCode,
  input  wire [15:0] cmdData,
  output reg  [15:0] readData,
  output reg         readValid,
  // pins
  input  wire        pwmClk,
  input  wire [15:0] powerInputVoltage,
  input  wire        enable,
  // fault handling
  input  wire        clearFaults,
  output reg         switching,
  output wire        latchedOff,
  // status
  output reg         noneOfTheAbove,
  output reg         inputFlag,
  output reg         overvoltageFlag,
  output reg         undervoltageWarningFlag,
  output reg         invalidDataFlag,
  output wire        hostNotify
);

  localparam ST_OFF    = 3'h0;
  localparam ST_RUN    = 3'h1;
  localparam ST_DELAY  = 3'h2;
  localparam ST_HICCUP = 3'h3;
  localparam ST_LATCH  = 3'h4;

  reg  [2:0]        state;
  reg  [2:0]        next_state;
  reg  [7:0]        responseConfig;
  reg  [15:0]       uvWarnLimit;
  reg  [15:0]       ovLimit;
  reg               uvLocked;
  reg  [2:0]        attempts;
  reg  [2:0]        next_attempts;
  reg               pwmLast;
  reg               ovLast;
  reg               uvLast;
  reg  [15:0]       vinPrev;
  reg  [15:0]       vinStable;
  reg               timerLoad;
  reg  [TWIDTH-1:0] timerValue;
  reg               timerTick;
  reg               goHiccup;
  reg               writeOk;
  wire              pwmSync;
  wire [15:0]       vinSync;
  wire              enableSync;
  wire              timerDone;
  wire              pwmEdge;
  wire [1:0]        overvoltageActionCode;
  wire [2:0]        overvoltageRestartCount;
  wire [2:0]        overvoltageDelaySelector;
  wire signed [31:0] vinValue;
  wire signed [31:0] ovThreshold;
  wire signed [31:0] uvThreshold;
  wire signed [31:0] writeValue;
  wire              ovFault;
  wire              uvCondition;
  wire              ovEvent;
  wire              uvEvent;
  wire [3:0]        delayCycles;
  wire [TWIDTH-1:0] hiccupCycles;
  wire [TWIDTH-1:0] riseCycles;

  // word value in sensed units
  function signed [31:0] linearValue;
    input [15:0] word;
    reg signed [31:0] mant;
    reg signed [7:0]  shift;
    begin
      mant  = {{21{word[`IVFR_MAN_MSB]}}, word[`IVFR_MAN_MSB:`IVFR_MAN_LSB]};
      shift = {{3{word[`IVFR_EXP_MSB]}}, word[`IVFR_EXP_MSB:`IVFR_EXP_LSB]} + 8'sd`IVFR_VOLT_FRAC;
      if (shift >= 0)
        linearValue = mant <<< shift;
      else
        linearValue = mant >>> (-shift);
    end
  endfunction

  // pin synchronisers
  ivfr_sync #(
    .WIDTH (1)
  ) u_pwm_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (pwmClk),
    .dout (pwmSync)
  );

  ivfr_sync #(
    .WIDTH (17)
  ) u_pin_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({enable, powerInputVoltage}),
    .dout ({enableSync, vinSync})
  );

  ivfr_timer #(
    .WIDTH (TWIDTH)
  ) u_timer (
    .clk       (clk),
    .rst       (rst),
    .load      (timerLoad),
    .loadValue (timerValue),
    .tick      (timerTick),
    .expired   (timerDone)
  );

  assign overvoltageActionCode    = responseConfig[`IVFR_ACTION_MSB:`IVFR_ACTION_LSB];
  assign overvoltageRestartCount  = responseConfig[`IVFR_RETRY_MSB:`IVFR_RETRY_LSB];
  assign overvoltageDelaySelector = responseConfig[`IVFR_DELAY_MSB:`IVFR_DELAY_LSB];

  assign vinValue    = {16'h0000, vinStable};
  assign ovThreshold = linearValue(ovLimit);
  assign uvThreshold = linearValue(uvWarnLimit);
  assign writeValue  = linearValue(cmdData);
  assign ovFault     = (vinValue > ovThreshold);
  assign uvCondition = (vinValue <= uvThreshold);
  assign ovEvent     = ovFault && !ovLast;
  assign uvEvent     = uvCondition && !uvLast;
  assign pwmEdge     = pwmSync && !pwmLast;
  assign latchedOff  = (state == ST_LATCH);
  assign hostNotify  = overvoltageFlag | undervoltageWarningFlag | invalidDataFlag;
  assign riseCycles  = RISE_CYCLES[TWIDTH-1:0];

  // shutdown delay and hiccup length
  assign delayCycles = (overvoltageDelaySelector <= 3'h1) ? `IVFR_DLY_SHORT :
                       (overvoltageDelaySelector <= 3'h4) ? `IVFR_DLY_MID :
                       `IVFR_DLY_LONG;
  assign hiccupCycles = (overvoltageDelaySelector <= 3'h1) ? riseCycles :
                        riseCycles * overvoltageDelaySelector;

  // write validation
  always @*
  begin
    writeOk = 1'b0;
    if (cmdCode == `IVFR_CMD_OV_RESPONSE)
      writeOk = (cmdData[`IVFR_ACTION_MSB:`IVFR_ACTION_LSB] != `IVFR_ACT_INVALID) &&
                (cmdData[15:8] == 8'h00);
    else if (cmdCode == `IVFR_CMD_UV_WARN_LIMIT)
      writeOk = (writeValue >= `IVFR_VOLT_MIN) && (writeValue <= `IVFR_VOLT_MAX) &&
                !(uvLocked && (writeValue < `IVFR_VOLT_MIN));
    else if (cmdCode == `IVFR_CMD_OV_LIMIT)
      writeOk = (writeValue >= `IVFR_VOLT_MIN) && (writeValue <= `IVFR_VOLT_MAX) &&
                ((writeValue & `IVFR_VOLT_STEP_MASK) == 32'sh00000000);
  end

  // command registers and read data
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      responseConfig <= `IVFR_RST_OV_RESPONSE;
      uvWarnLimit    <= `IVFR_RST_UV_WARN;
      ovLimit        <= `IVFR_RST_OV_LIMIT;
      uvLocked       <= 1'b0;
      readData       <= 16'h0000;
      readValid      <= 1'b0;
    end
    else
    begin
      readValid <= cmdValid && !cmdWrite;
      if (cmdValid && cmdWrite && writeOk)
      begin
        if (cmdCode == `IVFR_CMD_OV_RESPONSE)
          responseConfig <= cmdData[7:0];
        else if (cmdCode == `IVFR_CMD_UV_WARN_LIMIT)
        begin
          uvWarnLimit <= cmdData;
          if (writeValue > `IVFR_VOLT_MIN)
            uvLocked <= 1'b1;
        end
        else if (cmdCode == `IVFR_CMD_OV_LIMIT)
          ovLimit <= cmdData;
      end
      if (cmdValid && !cmdWrite)
      begin
        if (cmdCode == `IVFR_CMD_OV_RESPONSE)
          readData <= {8'h00, responseConfig};
        else if (cmdCode == `IVFR_CMD_UV_WARN_LIMIT)
          readData <= uvWarnLimit;
        else if (cmdCode == `IVFR_CMD_OV_LIMIT)
          readData <= ovLimit;
        else
          readData <= 16'h0000;
      end
    end
  end

  // sticky status, set wins over clear
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      noneOfTheAbove          <= 1'b0;
      inputFlag               <= 1'b0;
      overvoltageFlag         <= 1'b0;
      undervoltageWarningFlag <= 1'b0;
      invalidDataFlag         <= 1'b0;
      ovLast                  <= 1'b0;
      uvLast                  <= 1'b1; // no false warning from sync reset value
      pwmLast                 <= 1'b0;
      vinPrev                 <= 16'h0000;
      vinStable               <= 16'h0000;
    end
    else
    begin
      ovLast  <= ovFault;
      uvLast  <= uvCondition;
      pwmLast <= pwmSync;
      vinPrev <= vinSync;
      if (vinSync == vinPrev)
        vinStable <= vinSync; // word taken once two samples agree
      if (ovEvent || uvEvent)
      begin
        noneOfTheAbove <= 1'b1;
        inputFlag      <= 1'b1;
      end
      else if (clearFaults)
      begin
        noneOfTheAbove <= 1'b0;
        inputFlag      <= 1'b0;
      end
      if (ovEvent)
        overvoltageFlag <= 1'b1;
      else if (clearFaults)
        overvoltageFlag <= 1'b0;
      if (uvEvent)
        undervoltageWarningFlag <= 1'b1;
      else if (clearFaults)
        undervoltageWarningFlag <= 1'b0;
      if (cmdValid && cmdWrite && !writeOk)
        invalidDataFlag <= 1'b1;
      else if (clearFaults)
        invalidDataFlag <= 1'b0;
    end
  end

  // response state machine
  always @*
  begin
    next_state    = state;
    next_attempts = attempts;
    timerLoad     = 1'b0;
    timerValue    = {TWIDTH{1'b0}};
    timerTick     = (state == ST_DELAY) ? pwmEdge : 1'b1;
    goHiccup      = 1'b0;
    case (state)
      ST_OFF:
      begin
        next_attempts = 3'h0;
        if (enableSync && !ovFault)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!enableSync)
          next_state = ST_OFF;
        else if (ovFault)
        begin
          if (overvoltageActionCode == `IVFR_ACT_DELAYED)
          begin
            next_state = ST_DELAY;
            timerLoad  = 1'b1;
            timerValue = {{(TWIDTH-4){1'b0}}, delayCycles};
          end
          else if (overvoltageActionCode == `IVFR_ACT_IMMEDIATE)
            goHiccup = 1'b1;
          // ignore keeps running
        end
      end
      ST_DELAY:
      begin
        if (!enableSync)
          next_state = ST_OFF;
        else if (timerDone)
        begin
          if (ovFault)
            goHiccup = 1'b1;
          else
            next_state = ST_RUN;
        end
      end
      ST_HICCUP:
      begin
        if (!enableSync)
          next_state = ST_OFF;
        else if (timerDone)
        begin
          next_attempts = attempts + 3'h1;
          if (!ovFault)
          begin
            next_state    = ST_RUN;
            next_attempts = 3'h0;
          end
          else if (overvoltageRestartCount == `IVFR_RETRY_ENDLESS)
          begin
            timerLoad     = 1'b1;
            timerValue    = hiccupCycles;
            next_attempts = 3'h0;
          end
          else if (next_attempts >= overvoltageRestartCount)
            next_state = ST_LATCH;
          else
          begin
            timerLoad  = 1'b1;
            timerValue = hiccupCycles;
          end
        end
      end
      ST_LATCH:
      begin
        if (!enableSync)
          next_state = ST_OFF;
      end
      default:
        next_state = ST_OFF;
    endcase
    if (goHiccup)
    begin
      next_attempts = 3'h0;
      if (overvoltageRestartCount == `IVFR_RETRY_LATCH)
        next_state = ST_LATCH;
      else
      begin
        next_state = ST_HICCUP;
        timerLoad  = 1'b1;
        timerValue = hiccupCycles;
      end
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_OFF;
      attempts  <= 3'h0;
      switching <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      attempts  <= next_attempts;
      switching <= (next_state == ST_RUN) || (next_state == ST_DELAY);
    end
  end

endmodule // ivfr_top

/* ivfr_consts.vh */
// constants for the input voltage fault response block
`ifndef IVFR_CONSTS_VH
`define IVFR_CONSTS_VH

// command codes
`define IVFR_CMD_OV_LIMIT      8'h55
`define IVFR_CMD_OV_RESPONSE   8'h56
`define IVFR_CMD_UV_WARN_LIMIT 8'h58

// response config fields
`define IVFR_ACTION_MSB        7
`define IVFR_ACTION_LSB        6
`define IVFR_RETRY_MSB         5
`define IVFR_RETRY_LSB         3
`define IVFR_DELAY_MSB         2
`define IVFR_DELAY_LSB         0

// action codes
`define IVFR_ACT_IGNORE        2'h0
`define IVFR_ACT_DELAYED       2'h1
`define IVFR_ACT_IMMEDIATE     2'h2
`define IVFR_ACT_INVALID       2'h3

// restart counts
`define IVFR_RETRY_LATCH       3'h0
`define IVFR_RETRY_ENDLESS     3'h7

// threshold word fields
`define IVFR_EXP_MSB           15
`define IVFR_EXP_LSB           11
`define IVFR_MAN_MSB           10
`define IVFR_MAN_LSB           0

// reset values: exponent 11110b, uv warning 2.5 V, ov limit 20 V
`define IVFR_RST_OV_RESPONSE   8'h80
`define IVFR_RST_UV_WARN       16'hF00A
`define IVFR_RST_OV_LIMIT      16'hF050

// shutdown delays in switching cycles
`define IVFR_DLY_SHORT         4'h3
`define IVFR_DLY_MID           4'h5
`define IVFR_DLY_LONG          4'h9

// voltages in sensed units (8 fraction bits)
`define IVFR_VOLT_FRAC         8
`define IVFR_VOLT_MIN          32'sh00000500
`define IVFR_VOLT_MAX          32'sh00001600
`define IVFR_VOLT_STEP_MASK    32'sh0000003F

// soft-start rise time and clock
`define IVFR_RISE_TIME_US      1000
`define IVFR_CLK_PERIOD_PS     4000

`endif

/* ivfr_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ivfr_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // data
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // ivfr_sync

/* ivfr_timer.v */
// loadable down counter with tick enable
`timescale 1ns/100ps
module ivfr_timer #(
  parameter WIDTH = 24
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  input  wire             tick,
  // status
  output wire             expired
);

  reg [WIDTH-1:0] count;

  assign expired = (count == {WIDTH{1'b0}});

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= {WIDTH{1'b0}};
    else if (load)
      count <= loadValue;
    else if (tick && !expired)
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
  end

endmodule // ivfr_timer

/* ivfr_top_sva.sv */
// assertions for the input voltage fault response block
`timescale 1ns/100ps
module ivfr_top_sva #(
  parameter RISE_CYCLES = 20,
  parameter TWIDTH      = 24
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // command port
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdCode,
  input wire logic [15:0] cmdData,
  input wire logic [15:0] readData,
  input wire logic        readValid,
  // pins
  input wire logic        pwmClk,
  input wire logic [15:0] powerInputVoltage,
  input wire logic        enable,
  // fault handling
  input wire logic        clearFaults,
  input wire logic        switching,
  input wire logic        latchedOff,
  // status
  input wire logic        noneOfTheAbove,
  input wire logic        inputFlag,
  input wire logic        overvoltageFlag,
  input wire logic        undervoltageWarningFlag,
  input wire logic        invalidDataFlag,
  input wire logic        hostNotify
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rdReq;
  wire logic wrReq;
  assign rdReq = cmdValid && !cmdWrite;
  assign wrReq = cmdValid && cmdWrite;
  read_ans_a: assert property (rdReq |=> readValid) else $error("read not answered");
  read_only_a: assert property (!rdReq |=> !readValid) else $error("stray read answer");
  notify_or_a: assert property (hostNotify == (overvoltageFlag || undervoltageWarningFlag || invalidDataFlag))
    else $error("notify not tied to flags");
  ov_status_a: assert property ($rose(overvoltageFlag) |-> noneOfTheAbove && inputFlag)
    else $error("ov status bits missing");
  uv_status_a: assert property ($rose(undervoltageWarningFlag) |-> noneOfTheAbove && inputFlag)
    else $error("uv status bits missing");
  bad_action_a: assert property (wrReq && cmdCode == 8'h56 && cmdData[7:6] == 2'h3 |=> invalidDataFlag)
    else $error("action 11b accepted");
  low_uv_a: assert property (wrReq && cmdCode == 8'h58 && cmdData[15:11] == 5'h1E
    && cmdData[10:0] < 11'h014 |=> invalidDataFlag) else $error("low uv limit accepted");
  latch_quiet_a: assert property (latchedOff |-> !switching) else $error("switching while latched");
  off_cmd_a: assert property (!enable [*6] |-> !switching && !latchedOff) else $error("not off");
  cover property ($rose(latchedOff));
  cover property ($rose(invalidDataFlag));
  cover property ($rose(undervoltageWarningFlag));
endmodule // ivfr_top_sva
bind ivfr_top ivfr_top_sva #(.RISE_CYCLES(RISE_CYCLES), .TWIDTH(TWIDTH)) chk_u (.clk(clk), .rst(rst),
  .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .readData(readData),
  .readValid(readValid), .pwmClk(pwmClk), .powerInputVoltage(powerInputVoltage), .enable(enable),
  .clearFaults(clearFaults), .switching(switching), .latchedOff(latchedOff), .noneOfTheAbove(noneOfTheAbove),
  .inputFlag(inputFlag), .overvoltageFlag(overvoltageFlag), .undervoltageWarningFlag(undervoltageWarningFlag),
  .invalidDataFlag(invalidDataFlag), .hostNotify(hostNotify));

/* ivfr_host_model.sv */
// host model issuing commands on the command port
`timescale 1ns/100ps
module ivfr_host_model (
  // clock
  input  wire logic        clk,
  // command port
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdCode,
  output logic [15:0]      cmdData
);
  initial
  begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdData  = 16'h0000;
  end
  // one strobe, then lines scrambled so stale values never match
  task xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdCode  <= c;
    cmdData  <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdCode  <= ~c;
    cmdData  <= ~d;
  endtask
endmodule // ivfr_host_model

/* ivfr_top_tb.sv */
// self-checking testbench for the input voltage fault response block
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errTotal++; $display("[FAIL] %0t got %h", $time, a); end end
module ivfr_top_tb;
  localparam H = 20;
  localparam OVV = 16'h1600;
  logic        clk, rst, pwmClk, enable, clearFaults;
  logic [15:0] vin;
  wire         cmdValid, cmdWrite, readValid, switching, latchedOff;
  wire         noneOfTheAbove, inputFlag, overvoltageFlag, undervoltageWarningFlag, invalidDataFlag, hostNotify;
  wire  [7:0]  cmdCode;
  wire  [15:0] cmdData, readData;
  logic [15:0] expQ[$];
  int          errTotal, compares, cyc, seed, k;
  int          cfgs[3] = '{8'h80, 8'h88, 8'h93};
  int          lats[3] = '{0, H, 6 * H};
  int          sels[3] = '{0, 2, 5};
  int          dlys[3] = '{3, 5, 9};
  initial begin clk = 0; forever #2 clk = ~clk; end
  initial begin pwmClk = 0; #7; forever #32 pwmClk = ~pwmClk; end
  ivfr_host_model host_u (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData));
  ivfr_top #(.RISE_CYCLES(H)) dut_u (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdData(cmdData), .readData(readData), .readValid(readValid), .pwmClk(pwmClk),
    .powerInputVoltage(vin), .enable(enable), .clearFaults(clearFaults), .switching(switching),
    .latchedOff(latchedOff), .noneOfTheAbove(noneOfTheAbove), .inputFlag(inputFlag),
    .overvoltageFlag(overvoltageFlag), .undervoltageWarningFlag(undervoltageWarningFlag),
    .invalidDataFlag(invalidDataFlag), .hostNotify(hostNotify));
  always @(posedge clk) if (readValid === 1'b1) `CHK(readData, expQ.pop_front())
  always @(posedge clk) begin cyc++; if (cyc > 6000) begin errTotal++; results; end end
  task results;
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e); expQ.push_back(e); host_u.xfer(1'b0, c, 16'h0000); endtask
  task setv(input logic [15:0] v); @(posedge clk) vin <= v; endtask
  task wt(input int n); repeat (n) @(posedge clk); #1; endtask
  task clr; @(posedge clk) clearFaults <= 1'b1; @(posedge clk) clearFaults <= 1'b0; endtask
  task start(input logic [7:0] cfg);
    host_u.xfer(1'b1, 8'h56, {8'h00, cfg});
    @(posedge clk) enable <= 1'b1;
    wt(12); `CHK(switching, 1'b1)
  endtask
  task stop; @(posedge clk) enable <= 1'b0; vin <= 16'h0C00; wt(10); `CHK(latchedOff, 1'b0) clr; endtask
  initial
  begin
    seed = 79; rst = 1; enable = 0; clearFaults = 0; vin = 16'h0C00; errTotal = 0; compares = 0; cyc = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h56, 16'h0080); rd(8'h58, 16'hF00A); rd(8'h55, 16'hF050);
    $display("reset values done");
    host_u.xfer(1'b1, 8'h56, 16'h00C0); host_u.xfer(1'b1, 8'h58, 16'hF008);
    wt(1); `CHK({invalidDataFlag, hostNotify}, 2'b11)
    rd(8'h56, 16'h0080); rd(8'h58, 16'hF00A);
    clr; wt(1); `CHK(hostNotify, 1'b0)
    host_u.xfer(1'b1, 8'h55, 16'hF054); // above start-up input
    host_u.xfer(1'b1, 8'h55, 16'hE8A9); wt(1); `CHK(invalidDataFlag, 1'b1)
    host_u.xfer(1'b1, 8'h58, 16'hF028); host_u.xfer(1'b1, 8'h58, 16'hF010);
    rd(8'h55, 16'hF054); rd(8'h58, 16'hF028);
    clr; $display("limits done");
    repeat (4) begin setv(16'h0A80 + ($random(seed) & 16'h07FF)); wt(8); `CHK(undervoltageWarningFlag, 1'b0) end
    setv(16'h0A00); wt(6); `CHK({undervoltageWarningFlag, noneOfTheAbove, inputFlag}, 3'b111)
    setv(16'h0C00); clr; wt(1); `CHK(hostNotify, 1'b0)
    $display("uv warning done");
    for (k = 0; k < 3; k++) begin
      start(cfgs[k][7:0]); setv(OVV); wt(6);
      `CHK({switching, overvoltageFlag, noneOfTheAbove, inputFlag}, 4'b0111)
      if (lats[k] > 0) begin wt(lats[k] - 8); `CHK(latchedOff, 1'b0) wt(20); end
      `CHK(latchedOff, 1'b1)
      stop;
    end
    start(8'hB8); setv(OVV); wt(150); `CHK(latchedOff, 1'b0)
    setv(16'h0C00); wt(30); `CHK(switching, 1'b1) stop;
    $display("restart policy done");
    for (k = 0; k < 3; k++) begin
      start(8'h40 | sels[k][7:0]); setv(OVV); wt((dlys[k] - 1) * 16); `CHK(switching, 1'b1)
      wt(30); `CHK({switching, latchedOff}, 2'b01) stop;
    end
    $display("delayed shutdown done");
    start(8'h00); setv(OVV); wt(100); `CHK({switching, overvoltageFlag}, 2'b11)
    @(posedge clk) enable <= 1'b0; wt(10); @(posedge clk) enable <= 1'b1;
    wt(20); `CHK(switching, 1'b0)
    setv(16'h0C00); wt(20); `CHK(switching, 1'b1) stop;
    $display("ignore action done");
    results;
  end
endmodule // ivfr_top_tb
